// [snsc_status_config.sv]
// serial command front end, status register three and volatile config table
// assumes a single-line mode-0 serial host; link pins are asynchronous to clk_i
// Operation
// - program timeout sets fail, success clears it
// - program on protected area sets fail
// - program start or reset clears fail
// - erase timeout sets fail, success clears it
// - erase on protected area sets fail
// - erase start or reset clears fail
// - write enable sets latch bit S1
// - latch cleared by disable, program, erase, read
// - busy bit S0 during power-up and operations
// - busy ignores all but status, reset, id
// - busy returns to zero when done
// - reset loads defaults into table and config
// - table write updates configuration at once
// - reserved entries read FFh, writes clear latch
// - no switch to octal double rate while protect enabled
// - entry 01h selects fast read dummy cycles
// - entry 00h selects io mode and strobe
// - entry 03h selects output drive strength
// - flags read in status address Cxh
`timescale 1ns/1ps
`default_nettype none
module snsc_status_config #(
	parameter int OP_CYCLES_P = snsc_pkg::OP_CYCLES,
	parameter int PWRUP_CYCLES_P = snsc_pkg::PWRUP_CYCLES,
	// identification byte, value arbitrary
	parameter logic [7:0] ID_BYTE_P = 8'h5a
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// serial link
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	// array side
	input wire logic prot_hit_i,
	input wire logic op_fail_i,
	input wire logic wp_enable_i,
	// status
	output logic busy_o,
	output logic write_enable_latch_o,
	output logic pfail_o,
	output logic efail_o,
	// configuration in force
	output snsc_pkg::snsc_io_mode_t io_mode_o,
	output logic [4:0] dummy_cycles_o,
	output logic [1:0] drive_level_o
);
	import snsc_pkg::*;

	typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE} snsc_spi_state_t;

	// ****************************************
	// decoding functions
	// ****************************************
	function automatic logic allowed_when_busy(input logic [7:0] op);
		allowed_when_busy = (op == OP_RDSR) || (op == OP_RST) || (op == OP_JEDEC);
	endfunction

	function automatic logic is_rsvd_addr(input logic [7:0] a);
		is_rsvd_addr = (a >= 8'(VCR_ENTRIES)) || (a == VCR_RSVD2) || (a == VCR_RSVD4);
	endfunction

	function automatic logic is_octal_double_rate(input logic [7:0] c);
		is_octal_double_rate = (c == IO_OCTAL_DOUBLE_RATE_STROBE) || (c == IO_OCTAL_DOUBLE_RATE_PLAIN);
	endfunction

	function automatic logic code_valid(input logic [7:0] a, input logic [7:0] c);
		case (a)
			VCR_IO_MODE: code_valid = (c == IO_SINGLE_STROBE) || (c == IO_OCTAL_SDR) || is_octal_double_rate(c);
			VCR_DUMMY: code_valid = (c == DUMMY_DEFAULT_CODE) || ((c >= DUMMY_MIN_CODE) &&
				(c <= DUMMY_MAX_CODE) && (c[1:0] == 2'b00));
			VCR_DRIVE: code_valid = (c >= DRV_25) && (c <= DRV_100);
			default: code_valid = 1'b0;
		endcase
	endfunction

	function automatic snsc_io_mode_t io_decode(input logic [7:0] c);
		case (c)
			IO_OCTAL_SDR: io_decode = IOM_OCTAL_SDR;
			IO_OCTAL_DOUBLE_RATE_STROBE: io_decode = IOM_OCTAL_DOUBLE_RATE_STROBE;
			IO_OCTAL_DOUBLE_RATE_PLAIN: io_decode = IOM_OCTAL_DOUBLE_RATE_PLAIN;
			default: io_decode = IOM_SINGLE_STROBE;
		endcase
	endfunction

	// ****************************************
	// link synchronisers
	// ****************************************
	logic cs_n_s1_q, cs_n_s2_q, sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_n_s1_q <= 1'b1;
			cs_n_s2_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
		end else begin
			cs_n_s1_q <= cs_n_i;
			cs_n_s2_q <= cs_n_s1_q;
			sck_s1_q <= sck_i;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= si_i;
			si_s2_q <= si_s1_q;
		end
	end

	// ****************************************
	// state declarations
	// ****************************************
	snsc_spi_state_t state_q, state_d;
	logic [2:0] cnt_q, cnt_d, ocnt_q, ocnt_d;
	logic [7:0] shin_q, shin_d, cmd_q, cmd_d, addr_q, addr_d, osh_q, osh_d;
	logic so_q, so_d, oe_q, oe_d;
	logic wel_q, wel_d, pfail_q, pfail_d, efail_q, efail_d;
	snsc_op_kind_t kind_q, kind_d;
	logic [7:0] vcr_q [VCR_ENTRIES];
	logic [7:0] vcr_d [VCR_ENTRIES];
	snsc_io_mode_t io_q, io_d;
	logic [4:0] dummy_q, dummy_d;
	logic [1:0] drive_q, drive_d;

	logic sel, sck_rise, sck_fall, byte_done, cmd_done, cmd_ok;
	logic [7:0] byte_in, status3, rd_val;
	logic exec_wren, exec_wrdi, exec_rst, exec_prog, exec_erase, exec_other;
	logic prog_go, erase_go, op_start, wr_done, wr_accept;
	logic busy, op_done;

	// ****************************************
	// operation timer
	// ****************************************
	snsc_op_timer #(
		.OP_CYCLES_P(OP_CYCLES_P),
		.PWRUP_CYCLES_P(PWRUP_CYCLES_P)
	) u_timer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(op_start),
		.abort_i(exec_rst),
		.busy_o(busy),
		.done_o(op_done)
	);

	// ****************************************
	// command decode
	// ****************************************
	assign sel = ~cs_n_s2_q;
	assign sck_rise = sel & sck_s2_q & ~sck_s3_q;
	assign sck_fall = sel & ~sck_s2_q & sck_s3_q;
	assign byte_in = {shin_q[6:0], si_s2_q};
	assign byte_done = sck_rise & (cnt_q == 3'd7);
	assign cmd_done = byte_done & (state_q == ST_CMD);
	assign cmd_ok = ~busy | allowed_when_busy(byte_in);
	assign exec_wren = cmd_done & cmd_ok & (byte_in == OP_WREN);
	assign exec_wrdi = cmd_done & cmd_ok & (byte_in == OP_WRDI);
	assign exec_rst = cmd_done & (byte_in == OP_RST);
	assign exec_prog = cmd_done & cmd_ok & wel_q & (byte_in == OP_PGEXE);
	assign exec_erase = cmd_done & cmd_ok & wel_q & (byte_in == OP_BERASE);
	assign exec_other = cmd_done & cmd_ok &
		((byte_in == OP_PGREAD) || (byte_in == OP_BBM) || (byte_in == OP_CONTRD));
	assign prog_go = exec_prog & ~prot_hit_i;
	assign erase_go = exec_erase & ~prot_hit_i;
	assign op_start = prog_go | erase_go | exec_other;
	assign wr_done = byte_done & (state_q == ST_DATA_IN) & (cmd_q == OP_WRVCR);
	assign wr_accept = wr_done & wel_q & ~is_rsvd_addr(addr_q) & code_valid(addr_q, byte_in) &
		~((addr_q == VCR_IO_MODE) & wp_enable_i & is_octal_double_rate(byte_in));

	always_comb begin
		status3 = 8'h00;
		status3[ST_BUSY_BIT] = busy;
		status3[ST_WEL_BIT] = wel_q;
		status3[ST_EFAIL_BIT] = efail_q;
		status3[ST_PFAIL_BIT] = pfail_q;
	end

	always_comb begin
		rd_val = 8'h00;
		if (cmd_q == OP_JEDEC) begin
			rd_val = ID_BYTE_P;
		end else if (cmd_q == OP_RDSR) begin
			rd_val = (addr_q[7:4] == STATUS3_ADDR_HI) ? status3 : 8'h00;
		end else if (cmd_q == OP_RDVCR) begin
			rd_val = is_rsvd_addr(addr_q) ? VCR_RSVD_VALUE : vcr_q[addr_q[2:0]];
		end
	end

	// ****************************************
	// serial framing
	// ****************************************
	always_comb begin
		logic [7:0] ob;
		ob = osh_q;
		state_d = state_q;
		cnt_d = cnt_q;
		shin_d = shin_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		osh_d = osh_q;
		ocnt_d = ocnt_q;
		so_d = so_q;
		oe_d = oe_q;
		if (!sel) begin
			state_d = ST_CMD;
			cnt_d = 3'd0;
			ocnt_d = 3'd0;
			oe_d = 1'b0;
		end else begin
			if (sck_rise) begin
				shin_d = byte_in;
				cnt_d = cnt_q + 3'd1;
			end
			if (byte_done) begin
				case (state_q)
					ST_CMD: begin
						cmd_d = byte_in;
						if (!cmd_ok) begin
							state_d = ST_IGNORE;
						end else if ((byte_in == OP_RDSR) || (byte_in == OP_RDVCR) ||
							(byte_in == OP_WRVCR)) begin
							state_d = ST_ADDR;
						end else if (byte_in == OP_JEDEC) begin
							state_d = ST_DATA_OUT;
						end else begin
							state_d = ST_IGNORE;
						end
					end
					ST_ADDR: begin
						addr_d = byte_in;
						state_d = (cmd_q == OP_WRVCR) ? ST_DATA_IN : ST_DATA_OUT;
					end
					ST_DATA_IN: state_d = ST_IGNORE;
					default: state_d = state_q;
				endcase
			end
			// live value reloaded every byte so busy polling sees updates
			if (sck_fall && (state_q == ST_DATA_OUT)) begin
				ob = (ocnt_q == 3'd0) ? rd_val : osh_q;
				so_d = ob[7];
				osh_d = {ob[6:0], 1'b0};
				ocnt_d = ocnt_q + 3'd1;
				oe_d = 1'b1;
			end
		end
	end

	// ****************************************
	// status flags and configuration
	// ****************************************
	always_comb begin
		wel_d = wel_q;
		pfail_d = pfail_q;
		efail_d = efail_q;
		kind_d = kind_q;
		vcr_d = vcr_q;
		if (exec_wren) wel_d = 1'b1;
		if (exec_wrdi || exec_prog || exec_erase || exec_rst || wr_done ||
			(exec_other && (cmd_d == OP_PGREAD))) wel_d = 1'b0;
		// clears come first so that sets win
		if (prog_go || exec_rst) pfail_d = 1'b0;
		if (erase_go || exec_rst) efail_d = 1'b0;
		if (op_done && (kind_q == OPK_PROG)) pfail_d = op_fail_i;
		if (op_done && (kind_q == OPK_ERASE)) efail_d = op_fail_i;
		if (exec_prog && prot_hit_i) pfail_d = 1'b1;
		if (exec_erase && prot_hit_i) efail_d = 1'b1;
		if (op_done || exec_rst) kind_d = OPK_NONE;
		if (prog_go) kind_d = OPK_PROG;
		else if (erase_go) kind_d = OPK_ERASE;
		else if (exec_other) kind_d = OPK_OTHER;
		if (exec_rst) begin
			for (int i = 0; i < VCR_ENTRIES; i++) vcr_d[i] = VCR_RESET;
		end else if (wr_accept) begin
			vcr_d[addr_q[2:0]] = byte_in;
		end
		io_d = io_decode(vcr_d[VCR_IO_MODE[2:0]]);
		// dummy count, zero means per-instruction default
		dummy_d = (vcr_d[VCR_DUMMY[2:0]] == DUMMY_DEFAULT_CODE) ? 5'd0 :
			vcr_d[VCR_DUMMY[2:0]][4:0];
		// drive level, zero is full strength
		drive_d = ~vcr_d[VCR_DRIVE[2:0]][1:0];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_CMD;
			cnt_q <= 3'd0;
			ocnt_q <= 3'd0;
			shin_q <= 8'h00;
			cmd_q <= 8'h00;
			addr_q <= 8'h00;
			osh_q <= 8'h00;
			so_q <= 1'b0;
			oe_q <= 1'b0;
			wel_q <= 1'b0;
			pfail_q <= 1'b0;
			efail_q <= 1'b0;
			kind_q <= OPK_NONE;
			for (int i = 0; i < VCR_ENTRIES; i++) vcr_q[i] <= VCR_RESET;
			io_q <= IOM_SINGLE_STROBE;
			dummy_q <= 5'd0;
			drive_q <= 2'd0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ocnt_q <= ocnt_d;
			shin_q <= shin_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			osh_q <= osh_d;
			so_q <= so_d;
			oe_q <= oe_d;
			wel_q <= wel_d;
			pfail_q <= pfail_d;
			efail_q <= efail_d;
			kind_q <= kind_d;
			vcr_q <= vcr_d;
			io_q <= io_d;
			dummy_q <= dummy_d;
			drive_q <= drive_d;
		end
	end

	assign so_o = so_q;
	assign so_oe_o = oe_q;
	assign busy_o = busy;
	assign write_enable_latch_o = wel_q;
	assign pfail_o = pfail_q;
	assign efail_o = efail_q;
	assign io_mode_o = io_q;
	assign dummy_cycles_o = dummy_q;
	assign drive_level_o = drive_q;

	// ****************************************
	// checks
	// ****************************************
	property p_pfail_outcome;
		@(posedge clk_i) disable iff (!reset_n_i)
		(op_done && kind_q == OPK_PROG) |=> (pfail_q == $past(op_fail_i));
	endproperty
	a_pfail_outcome: assert property (p_pfail_outcome) else $error("program fail flag wrong");

	property p_pfail_protected;
		@(posedge clk_i) disable iff (!reset_n_i)
		(exec_prog && prot_hit_i) |=> pfail_q && !busy;
	endproperty
	a_pfail_protected: assert property (p_pfail_protected) else $error("protected program");

	property p_prog_start;
		@(posedge clk_i) disable iff (!reset_n_i)
		prog_go |=> !pfail_q && busy && !wel_q;
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("program start state wrong");

	property p_efail_protected;
		@(posedge clk_i) disable iff (!reset_n_i)
		(exec_erase && prot_hit_i) |=> efail_q;
	endproperty
	a_efail_protected: assert property (p_efail_protected) else $error("protected erase");

	property p_erase_start;
		@(posedge clk_i) disable iff (!reset_n_i)
		erase_go |=> !efail_q && busy;
	endproperty
	a_erase_start: assert property (p_erase_start) else $error("erase start state wrong");

	property p_wel_set;
		@(posedge clk_i) disable iff (!reset_n_i)
		exec_wren |=> wel_q;
	endproperty
	a_wel_set: assert property (p_wel_set) else $error("latch not set");

	property p_wel_clear;
		@(posedge clk_i) disable iff (!reset_n_i)
		(exec_wrdi || wr_done) |=> !wel_q;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");

	property p_busy_ignore;
		@(posedge clk_i) disable iff (!reset_n_i)
		(cmd_done && busy && !allowed_when_busy(byte_in)) |=> state_q == ST_IGNORE;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

	property p_octal_double_rate_guard;
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_done && addr_q == VCR_IO_MODE && wp_enable_i && is_octal_double_rate(byte_in))
			|=> $stable(io_q);
	endproperty
	a_octal_double_rate_guard: assert property (p_octal_double_rate_guard) else $error("octal double rate let in");

	property p_cfg_apply;
		@(posedge clk_i) disable iff (!reset_n_i)
		(wr_accept && addr_q == VCR_DRIVE) |=> drive_q == ~$past(byte_in[1:0]);
	endproperty
	a_cfg_apply: assert property (p_cfg_apply) else $error("drive not applied");

endmodule // snsc_status_config
`default_nettype wire

// [snsc_pkg.sv]
// constants, opcodes and types for the status and volatile configuration block
// assumes a 10 MHz system clock; all users import the whole package
package snsc_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int OP_TIME_NS = 20000;
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP_TIME_NS = 50000;
	localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// instruction codes
	// ****************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h0f;
	localparam logic [7:0] OP_RDVCR = 8'h85;
	localparam logic [7:0] OP_WRVCR = 8'h81;
	localparam logic [7:0] OP_RST = 8'hff;
	localparam logic [7:0] OP_JEDEC = 8'h9f;
	localparam logic [7:0] OP_PGEXE = 8'h10;
	localparam logic [7:0] OP_BERASE = 8'hd8;
	localparam logic [7:0] OP_PGREAD = 8'h13;
	localparam logic [7:0] OP_BBM = 8'ha1;
	localparam logic [7:0] OP_CONTRD = 8'h03;

	// ****************************************
	// status register three
	// ****************************************
	localparam logic [3:0] STATUS3_ADDR_HI = 4'hc;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_EFAIL_BIT = 2;
	localparam int ST_PFAIL_BIT = 3;

	// ****************************************
	// volatile configuration table
	// ****************************************
	localparam int VCR_ENTRIES = 5;
	localparam logic [7:0] VCR_IO_MODE = 8'h00;
	localparam logic [7:0] VCR_DUMMY = 8'h01;
	localparam logic [7:0] VCR_RSVD2 = 8'h02;
	localparam logic [7:0] VCR_DRIVE = 8'h03;
	localparam logic [7:0] VCR_RSVD4 = 8'h04;
	localparam logic [7:0] VCR_RESET = 8'hff;
	localparam logic [7:0] VCR_RSVD_VALUE = 8'hff;

	localparam logic [7:0] IO_SINGLE_STROBE = 8'hff;
	localparam logic [7:0] IO_OCTAL_SDR = 8'hdf;
	localparam logic [7:0] IO_OCTAL_DOUBLE_RATE_STROBE = 8'he7;
	localparam logic [7:0] IO_OCTAL_DOUBLE_RATE_PLAIN = 8'hc7;

	localparam logic [7:0] DUMMY_MIN_CODE = 8'h08;
	localparam logic [7:0] DUMMY_MAX_CODE = 8'h1c;
	localparam logic [7:0] DUMMY_DEFAULT_CODE = 8'hff;

	localparam logic [7:0] DRV_100 = 8'hff;
	localparam logic [7:0] DRV_25 = 8'hfc;

	typedef enum logic [1:0] {
		IOM_SINGLE_STROBE,
		IOM_OCTAL_SDR,
		IOM_OCTAL_DOUBLE_RATE_STROBE,
		IOM_OCTAL_DOUBLE_RATE_PLAIN
	} snsc_io_mode_t;

	typedef enum logic [1:0] {
		OPK_NONE,
		OPK_PROG,
		OPK_ERASE,
		OPK_OTHER
	} snsc_op_kind_t;

endpackage

// [snsc_op_timer.sv]
// internal operation timer: power-up busy, then one timed operation per start
// assumes start and abort are one-cycle pulses on clk_i
`timescale 1ns/1ps
`default_nettype none
module snsc_op_timer #(
	parameter int OP_CYCLES_P = snsc_pkg::OP_CYCLES,
	parameter int PWRUP_CYCLES_P = snsc_pkg::PWRUP_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// control
	input wire logic start_i,
	input wire logic abort_i,
	// state
	output logic busy_o,
	output logic done_o
);
	import snsc_pkg::*;

	localparam int CW = $clog2((OP_CYCLES_P > PWRUP_CYCLES_P ? OP_CYCLES_P : PWRUP_CYCLES_P) + 1);

	if (OP_CYCLES_P < 1 || PWRUP_CYCLES_P < 1) begin : g_chk
		$error("snsc_op_timer: cycle counts must be at least one");
	end

	logic [CW-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (abort_i) begin
			busy_d = 1'b0;
			cnt_d = '0;
		end else if (start_i) begin
			busy_d = 1'b1;
			cnt_d = CW'(OP_CYCLES_P);
		end else if (busy_q) begin
			if (cnt_q <= CW'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q - CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= CW'(PWRUP_CYCLES_P);
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;

	property p_busy_bounded;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(busy_q) |-> ##[1:1000] !busy_q;
	endproperty
	a_busy_bounded: assert property (p_busy_bounded) else $error("busy never ended");

endmodule // snsc_op_timer
`default_nettype wire

// [snsc_host_model.sv]
// host model: single-line mode-0 serial controller for the link pins
// assumes sck idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module snsc_host_model (
	// link pins
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	// ****************************************
	// frame engine
	// ****************************************
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end

	// one frame: nb bytes out msb first, then one byte in if rd
	task automatic frame(input logic [23:0] tx, input int nb, input bit rd,
		output logic [7:0] rx);
		rx = 8'h00;
		#37 cs_n_o = 1'b0;
		for (int i = 0; i < nb * 8 + (rd ? 8 : 0); i++) begin
			si_o = (i < nb * 8) ? tx[23 - i] : ~si_o;
			#400 sck_o = 1'b1;
			if (i >= nb * 8)
				rx = {rx[6:0], so_oe_i ? so_i : 1'bx};
			#400 sck_o = 1'b0;
		end
		#400 cs_n_o = 1'b1;
		// released data line must not keep its last level
		si_o = ~si_o;
		#400;
	endtask
endmodule // snsc_host_model
`default_nettype wire

// [testbench.sv]
// testbench: status flags and config table through the host model
// assumes the design files and snsc_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import snsc_pkg::*;
	localparam int OPC = 400;
	localparam int PUC = 120;
	localparam int LIMIT = 40000;
	// identification byte, value arbitrary
	localparam logic [7:0] ID = 8'h5a;
	logic clk_i;
	logic reset_n_i;
	logic prot_hit_i;
	logic op_fail_i;
	logic wp_enable_i;
	wire logic cs_n;
	wire logic sck;
	wire logic si;
	wire logic so;
	wire logic so_oe;
	wire logic busy_o;
	wire logic write_enable_latch;
	wire logic pfail;
	wire logic efail;
	snsc_io_mode_t io_mode;
	wire logic [4:0] dummy;
	wire logic [1:0] drive;
	logic [7:0] rx;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	wire logic [7:0] flags = {4'h0, pfail, efail, write_enable_latch, busy_o};
	wire logic [7:0] iom = {6'h0, io_mode};
	wire logic [7:0] dmy = {3'h0, dummy};
	wire logic [7:0] drv = {6'h0, drive};

	// ****************************************
	// design and host
	// ****************************************
	snsc_status_config #(.OP_CYCLES_P(OPC), .PWRUP_CYCLES_P(PUC), .ID_BYTE_P(ID)) u_dut (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
		.so_o(so), .so_oe_o(so_oe), .prot_hit_i(prot_hit_i), .op_fail_i(op_fail_i),
		.wp_enable_i(wp_enable_i), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch),
		.pfail_o(pfail), .efail_o(efail), .io_mode_o(io_mode), .dummy_cycles_o(dummy),
		.drive_level_o(drive));
	snsc_host_model u_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			miscompares++;
			give_verdict;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic fr(input logic [23:0] tx, input int nb, input bit rd);
		u_host.frame(tx, nb, rd, rx);
		@(posedge clk_i);
	endtask

	task automatic wren;
		fr({OP_WREN, 16'h0}, 1, 0);
	endtask

	task automatic wcfg(input logic [7:0] a, input logic [7:0] d);
		wren();
		fr({OP_WRVCR, a, d}, 3, 0);
	endtask

	task automatic rcfg(input logic [7:0] a);
		fr({OP_RDVCR, a, 8'h00}, 2, 1);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (busy_o !== 1'b0 && n < OPC + 20) begin
			@(negedge clk_i);
			n++;
		end
		// outcome flags settle one cycle after busy falls
		repeat (2) @(posedge clk_i);
	endtask

	task automatic start_op(input logic [7:0] op, input logic fail, input logic [7:0] s0);
		op_fail_i <= fail;
		wren();
		fr({op, 16'h0}, 2, 0);
		chk(flags, s0);
	endtask

	task automatic end_op(input logic [7:0] s1);
		wait_idle();
		chk(flags, s1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_powerup;
		chk(flags, 8'h01);
		reset_n_i <= 1'b1;
		wren();
		chk(flags, 8'h01);
		wait_idle();
		chk(flags, 8'h00);
		chk(iom, 8'h00);
		chk(dmy, 8'h00);
		chk(drv, 8'h00);
		for (int a = 0; a < 6; a++) begin
			rcfg(8'(a));
			chk(rx, 8'hff);
		end
	endtask

	task automatic t_wel;
		wren();
		chk(flags, 8'h02);
		fr({OP_RDSR, 8'hc5, 8'h00}, 2, 1);
		chk(rx, 8'h02);
		fr({OP_RDSR, 8'h35, 8'h00}, 2, 1);
		chk(rx, 8'h00);
		fr({OP_WRDI, 16'h0}, 1, 0);
		chk(flags, 8'h00);
	endtask

	task automatic t_cfg;
		logic [31:0] tab [18] = '{32'h00ff00ff, 32'h00df01df, 32'h00e702e7, 32'h00c703c7,
			32'h000003c7, 32'h01080808, 32'h010c0c0c, 32'h01101010, 32'h01141414,
			32'h01181818, 32'h011c1c1c, 32'h01ff00ff, 32'h010900ff, 32'h03ff00ff,
			32'h03fe01fe, 32'h03fd02fd, 32'h03fc03fc, 32'h030003fc};
		logic [7:0] ra [3] = '{8'h02, 8'h04, 8'h05};
		logic [7:0] got;
		for (int i = 0; i < 18; i++) begin
			wcfg(tab[i][31:24], tab[i][23:16]);
			got = (tab[i][25:24] == 2'h0) ? iom : ((tab[i][25:24] == 2'h1) ? dmy : drv);
			chk(got, tab[i][15:8]);
			chk(flags, 8'h00);
			rcfg(tab[i][31:24]);
			chk(rx, tab[i][7:0]);
		end
		foreach (ra[j]) begin
			wcfg(ra[j], 8'h00);
			chk(flags, 8'h00);
			rcfg(ra[j]);
			chk(rx, 8'hff);
		end
		wp_enable_i <= 1'b1;
		wcfg(VCR_IO_MODE, IO_SINGLE_STROBE);
		wcfg(VCR_IO_MODE, IO_OCTAL_DOUBLE_RATE_STROBE);
		chk(iom, 8'h00);
		chk(flags, 8'h00);
		wp_enable_i <= 1'b0;
		wcfg(VCR_IO_MODE, IO_OCTAL_DOUBLE_RATE_PLAIN);
		chk(iom, 8'h03);
	endtask

	task automatic t_prot;
		prot_hit_i <= 1'b1;
		wren();
		fr({OP_PGEXE, 16'h0}, 2, 0);
		chk(flags, 8'h08);
		wren();
		fr({OP_BERASE, 16'h0}, 2, 0);
		chk(flags, 8'h0c);
		prot_hit_i <= 1'b0;
	endtask

	task automatic t_prog;
		start_op(OP_PGEXE, 1'b1, 8'h05);
		wren();
		chk(flags, 8'h05);
		fr({OP_RDSR, 8'hc0, 8'h00}, 2, 1);
		chk(rx, 8'h05);
		end_op(8'h0c);
		start_op(OP_PGEXE, 1'b0, 8'h05);
		end_op(8'h04);
	endtask

	task automatic t_erase;
		start_op(OP_BERASE, 1'b1, 8'h01);
		fr({OP_JEDEC, 16'h0}, 1, 1);
		chk(rx, ID);
		end_op(8'h04);
		start_op(OP_BERASE, 1'b0, 8'h01);
		end_op(8'h00);
	endtask

	task automatic t_others;
		start_op(OP_PGREAD, 1'b0, 8'h01);
		end_op(8'h00);
		start_op(OP_BBM, 1'b0, 8'h03);
		end_op(8'h02);
		start_op(OP_CONTRD, 1'b0, 8'h03);
		end_op(8'h02);
	endtask

	task automatic t_reset;
		t_prot();
		start_op(OP_BBM, 1'b0, 8'h0f);
		fr({OP_RST, 16'h0}, 1, 0);
		chk(flags, 8'h00);
		chk(iom, 8'h00);
		chk(drv, 8'h00);
		rcfg(VCR_DRIVE);
		chk(rx, 8'hff);
	endtask

	task automatic give_verdict;
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		reset_n_i = 1'b0;
		prot_hit_i = 1'b0;
		op_fail_i = 1'b0;
		wp_enable_i = 1'b0;
		repeat (2) @(posedge clk_i);
		t_powerup();
		t_wel();
		t_cfg();
		t_prot();
		t_prog();
		t_erase();
		t_others();
		t_reset();
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
